// ---- rtl/cra_flags.sv ----
// sticky event flags with write-one/zero clear where set wins
`timescale 1ns/1ps
`default_nettype none
module cra_flags (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // events and clear
  input wire logic [4:0] set_in,
  input wire logic [4:0] clear_in,
  // state
  output var logic [4:0] flags
);
  import cra_pkg::*;

  // ---------------------------------------------------------------
  // flag storage
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags <= 5'h00;
    end else begin
      // a set arriving with a clear is kept
      flags <= (flags & ~clear_in) | set_in;
    end
  end
endmodule // cra_flags
`default_nettype wire

// ---- rtl/cra_pkg.sv ----
// shared constants and carrier types of the counter array control block
package cra_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CRA_ADDR_CTRL = 4'h0;   // array_control_status
  localparam logic [3:0] CRA_ADDR_IMASK = 4'h1;  // per-module flag interrupt enable
  localparam logic [3:0] CRA_ADDR_ISTAT = 4'h2;  // sticky event status
  localparam logic [3:0] CRA_ADDR_IEN = 4'h3;    // event interrupt mask
  localparam logic [3:0] CRA_ADDR_CNTL = 4'h4;   // counter low byte
  localparam logic [3:0] CRA_ADDR_CNTH = 4'h5;   // counter high byte

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CRA_NMOD = 5;
  localparam int CRA_RUN_BIT = 6;
  localparam logic [7:0] CRA_CTRL_RESET = 8'h00;
  localparam logic [4:0] CRA_MASK_RESET = 5'h00;
  localparam logic [15:0] CRA_CNT_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cra_bus_s;

endpackage

// ---- rtl/cra_top.sv ----
// counter array run control and capture/compare event flags
// Operation
// - counter holds while run bit is 0, counts while it is 1
// - bits 4..0 hold module event flags, bit n for module n
// - hardware sets a module flag on its match or capture
// - set flag with its interrupt enabled raises shared array request
// - hardware never clears a flag; software writes zero to clear
`timescale 1ns/1ps
`default_nettype none
module cra_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire cra_pkg::cra_bus_s bus,
  output var logic [7:0] rdata,
  // module events, same clock domain
  input wire logic [4:0] module_event,
  // counter state
  output var logic array_run,
  output var logic [15:0] counter,
  // interrupts
  output var logic array_irq,
  output var logic event_irq
);
  import cra_pkg::*;

  logic [4:0] event_flag;
  logic [4:0] flag_irq_en;
  logic [4:0] istat;
  logic [4:0] ien;
  logic [4:0] flag_clear;
  logic [4:0] istat_clear;
  logic [4:0] next_rise;
  logic [4:0] prev_flag;
  logic ctrl_wr;

  assign ctrl_wr = bus.wr && (bus.addr == CRA_ADDR_CTRL);

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      array_run <= CRA_CTRL_RESET[CRA_RUN_BIT];
    end else if (ctrl_wr) begin
      array_run <= bus.wdata[CRA_RUN_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_irq_en <= CRA_MASK_RESET;
    end else if (bus.wr && bus.addr == CRA_ADDR_IMASK) begin
      flag_irq_en <= bus.wdata[4:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ien <= CRA_MASK_RESET;
    end else if (bus.wr && bus.addr == CRA_ADDR_IEN) begin
      ien <= bus.wdata[4:0];
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      counter <= CRA_CNT_RESET;
    end else if (array_run) begin
      counter <= counter + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // event flags
  // ---------------------------------------------------------------
  // only a written zero clears; hardware path has no clear term
  assign flag_clear = ctrl_wr ? ~bus.wdata[4:0] : 5'h00;

  cra_flags u_flags (
    .clock(clock),
    .rst_n(rst_n),
    .set_in(module_event),
    .clear_in(flag_clear),
    .flags(event_flag)
  );

  // ---------------------------------------------------------------
  // shared array request
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      array_irq <= 1'b0;
    end else begin
      // follows the next flag value so the request shows with the flag
      array_irq <= |(((event_flag & ~flag_clear) | module_event) & flag_irq_en);
    end
  end

  // ---------------------------------------------------------------
  // event status, write one to clear
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_flag <= 5'h00;
    end else begin
      prev_flag <= event_flag;
    end
  end

  assign next_rise = event_flag & ~prev_flag;
  assign istat_clear = (bus.wr && bus.addr == CRA_ADDR_ISTAT) ? bus.wdata[4:0] : 5'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      istat <= 5'h00;
    end else begin
      istat <= (istat & ~istat_clear) | next_rise;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(((istat & ~istat_clear) | next_rise) & ien);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        CRA_ADDR_CTRL: rdata <= {1'b0, array_run, 1'b0, event_flag};
        CRA_ADDR_IMASK: rdata <= {3'h0, flag_irq_en};
        CRA_ADDR_ISTAT: rdata <= {3'h0, istat};
        CRA_ADDR_IEN: rdata <= {3'h0, ien};
        CRA_ADDR_CNTL: rdata <= counter[7:0];
        CRA_ADDR_CNTH: rdata <= counter[15:8];
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // cra_top
`default_nettype wire

// ---- test/cra_top_properties.sv ----
// port assertions of the counter array block
`timescale 1ns/1ps
`default_nettype none
module cra_top_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // watched ports
  input wire cra_pkg::cra_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic [4:0] module_event,
  input wire logic array_run,
  input wire logic [15:0] counter,
  input wire logic array_irq,
  input wire logic event_irq
);
  import cra_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----
  // checks, two-edge run so either count timing passes
  // ----
  cnt_step_a:
    assert property (array_run && $past(array_run) |-> counter == $past(counter) + 16'h1)
    else $error("no step");
  cnt_hold_a:
    assert property (!array_run && !$past(array_run) |-> $stable(counter))
    else $error("moved");
  flag_set_a:
    assert property (bus.rd && bus.addr == CRA_ADDR_CTRL
      |=> (rdata[4:0] & $past(module_event, 2)) == $past(module_event, 2))
    else $error("flag lost");
  irq_cause_a:
    assert property ($rose(array_irq) |-> $past(module_event) != 5'h00 || $past(bus.wr, 2))
    else $error("bad rise");
  irq_keep_a:
    assert property (array_irq && !bus.wr
      && !($past(bus.wr) && $past(bus.addr) == CRA_ADDR_IMASK) |=> array_irq)
    else $error("dropped");
  bit5_zero_a:
    assert property (bus.rd && bus.addr == CRA_ADDR_CTRL |=> !rdata[5] && !rdata[7])
    else $error("bit set");
endmodule // cra_top_properties
bind cra_top cra_top_properties u_props (.clock, .rst_n, .bus, .rdata, .module_event,
  .array_run, .counter, .array_irq, .event_irq);
`default_nettype wire

// ---- test/tb.sv ----
// bench of the counter array block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cra_pkg::*;
  typedef struct {logic [4:0] ev; logic [7:0] rd; logic irq; logic [7:0] wd;} cra_row_s;
  cra_row_s rows [4] = '{'{5'h01, 8'h41, 1'b0, 8'hff}, '{5'h12, 8'h53, 1'b0, 8'hee},
    '{5'h0c, 8'h4e, 1'b1, 8'h00}, '{5'h00, 8'h00, 1'b0, 8'h40}};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  cra_bus_s bus = '0;
  logic [4:0] module_event = 5'h00;
  logic [7:0] rdata, v0, v1;
  logic array_run, array_irq, event_irq;
  logic [15:0] counter;
  int fails = 0;
  int tests_run = 0;
  always #20 clock = ~clock;
  cra_top u_cra_top (.clock, .rst_n, .bus, .rdata, .module_event, .array_run, .counter,
    .array_irq, .event_irq);
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) bus.wr <= 1'b0;
  endtask
  // pulse then read with no gap, so the new flag must show
  task automatic rd(input logic [3:0] a, input logic [4:0] e, output logic [7:0] v);
    @(posedge clock) module_event <= e;
    @(posedge clock) module_event <= 5'h00;
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (400) @(posedge clock);
    fails++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 chk({array_run, array_irq, event_irq, counter[12:0]}, 16'h0000, "reset");
    @(posedge clock) rst_n <= 1'b1;
    wr(CRA_ADDR_IMASK, 8'h04);
    wr(CRA_ADDR_CTRL, 8'h40);
    foreach (rows[i]) begin
      rd(CRA_ADDR_CTRL, rows[i].ev, v0);
      chk({8'h00, v0}, {8'h00, rows[i].rd}, "ctrl");
      chk({15'h0000, array_irq}, {15'h0000, rows[i].irq}, "airq");
      wr(CRA_ADDR_CTRL, rows[i].wd);
    end
    for (int r = 3; r >= 0; r -= 3) begin
      rd(CRA_ADDR_CNTL, 5'h00, v0);
      rd(CRA_ADDR_CNTL, 5'h00, v1);
      chk({8'h00, v1 - v0}, r[15:0], "count");
      wr(CRA_ADDR_CTRL, 8'h00);
    end
    rd(4'hf, 5'h00, v0);
    chk({8'h00, v0}, 16'h0000, "unmapped");
    wr(CRA_ADDR_ISTAT, 8'h1f);
    wr(CRA_ADDR_IEN, 8'h10);
    rd(CRA_ADDR_CTRL, 5'h01, v0);
    rd(CRA_ADDR_ISTAT, 5'h00, v0);
    chk({8'h00, v0}, 16'h0001, "istat");
    chk({15'h0000, event_irq}, 16'h0000, "masked");
    rd(CRA_ADDR_CTRL, 5'h10, v0);
    @(posedge clock) #1 chk({15'h0000, event_irq}, 16'h0001, "eirq");
    wr(CRA_ADDR_ISTAT, 8'h10);
    @(posedge clock) #1 chk({15'h0000, event_irq}, 16'h0000, "cleared");
    // mid-run reset while counting with flags held
    wr(CRA_ADDR_CTRL, 8'h5f);
    @(posedge clock) rst_n <= 1'b0;
    @(posedge clock) rst_n <= 1'b1;
    #1 chk({array_run, array_irq, event_irq, counter[12:0]}, 16'h0000, "rerun");
    rd(CRA_ADDR_CTRL, 5'h00, v0);
    chk({8'h00, v0}, 16'h0000, "reflag");
    @(posedge clock) #1 chk({8'h00, rdata}, 16'h0000, "idle");
    stop_test();
  end
endmodule // tb
`default_nettype wire
